// ### slps_pkg.sv
// Shared constants for the serial link packing and setup pair.
// Assumes both ends compile against this package; nothing is imported.
package slps_pkg;
    // ==========================================================
    // Register map (addresses and values of the setup writes)
    localparam logic [15:0] ADDR_SOFT_RESET = 16'h0000;
    localparam logic [15:0] ADDR_PATH_RESET = 16'h0001;
    localparam logic [15:0] ADDR_POWER_MODE = 16'h0002;
    localparam logic [15:0] ADDR_BW_MODE = 16'h0200;
    localparam logic [15:0] ADDR_DECIM = 16'h0201;
    localparam logic [15:0] ADDR_RATE_RANGE = 16'h056E;
    localparam logic [15:0] ADDR_LINK_CFG = 16'h0570;
    localparam logic [15:0] ADDR_LINK_CTRL = 16'h0571;
    localparam logic [15:0] ADDR_CS_NP = 16'h058B;
    localparam logic [15:0] ADDR_SUB_N = 16'h058F;
    localparam logic [15:0] ADDR_STARTUP = 16'h1228;
    localparam logic [15:0] ADDR_PLL_CAL = 16'h1222;
    localparam logic [15:0] ADDR_LOCK_CLR = 16'h1262;
    localparam logic [7:0] VAL_SOFT_RESET = 8'h81;
    localparam logic [7:0] VAL_PATH_RESET = 8'h02;
    localparam logic [7:0] VAL_LINK_OFF = 8'h15;
    localparam logic [7:0] VAL_LINK_ON = 8'h14;
    localparam logic [7:0] VAL_FULL_BW = 8'h00;
    localparam logic [7:0] VAL_QUAD_CFG = 8'hFE;
    localparam logic [7:0] VAL_CS_NP16 = 8'h0F;
    localparam logic [7:0] VAL_SUB1_N16 = 8'h2F;
    localparam logic [7:0] VAL_STARTUP_RST = 8'h4F;
    localparam logic [7:0] VAL_STARTUP_RUN = 8'h0F;
    localparam logic [7:0] VAL_PLL_NORMAL = 8'h00;
    localparam logic [7:0] VAL_PLL_CAL_RST = 8'h04;
    localparam logic [7:0] VAL_LOCK_CLEAR = 8'h08;
    localparam logic [7:0] VAL_LOCK_RUN = 8'h00;
    localparam logic [7:0] RATE_MID = 8'h00;
    localparam logic [7:0] RATE_LOW = 8'h10;
    localparam logic [7:0] RATE_HIGH = 8'h30;
    localparam logic [7:0] RATE_LOWEST = 8'h50;
    localparam logic [1:0] POWER_FIELD_ON = 2'h0;
    localparam logic [7:0] DECIM_RESET = 8'h01;
    // ==========================================================
    // Link parameters used in quad-rate packing
    localparam int LINK_L = 8;
    localparam int LINK_M = 2;
    localparam int LINK_F = 2;
    localparam int LINK_S = 4;
    localparam int LINK_NP = 16;
    localparam int LINK_N = 16;
    localparam int LINK_CS = 0;
    localparam int LINK_CF = 0;
    localparam int LINK_HD = 0;
    localparam int UNSUPPORTED_CF = 2;
    localparam int SAMPLE_W = 12;
    localparam int SAMPLES_PER_FRAME = 5;
    localparam int FRAME_W = 64;
    localparam int LANE_W = 8;
    localparam int SPARE_W = FRAME_W - SAMPLE_W * SAMPLES_PER_FRAME;
    localparam int LANE_BITS_PER_SAMPLE = 4;
    localparam int QUAD_RATE_MULT = 4;
    // Lane rate limits in Mbps
    localparam int RATE_MAX_MBPS = 16000;
    localparam int RATE_MIN_MBPS = 3400;
    localparam int RATE_LOWSEL_MBPS = 6250;
    localparam int RATE_LOW_TOP_MBPS = 6750;
    localparam int RATE_MID_TOP_MBPS = 13500;
    localparam int RATE_LOWEST_TOP_MBPS = 3375;
    // ==========================================================
    // Host sequencer
    typedef enum logic [1:0] {SLPS_OP_NONE, SLPS_OP_WRITE} slps_op_t;
    localparam int SEQ_LEN = 15;
endpackage : slps_pkg

// ### slps_link_if.sv
// Link between the host (receiver side) and the converter end.
// Carries the control-port writes toward the device and frames back.
interface slps_link_if;
    // Control port writes
    logic wrValid;
    logic wrReady;
    logic [15:0] wrAddr;
    logic [7:0] wrData;
    // Link status
    logic linkUp;
    logic [31:0] laneRateMbps;
    // Frames on the serial_output_lanes
    logic frameValid;
    logic frameReady;
    logic [slps_pkg::FRAME_W-1:0] frameData;

    modport device (input wrValid, wrAddr, wrData, frameReady,
        output wrReady, linkUp, laneRateMbps, frameValid, frameData);
    modport host (output wrValid, wrAddr, wrData, frameReady,
        input wrReady, linkUp, laneRateMbps, frameValid, frameData);
endinterface : slps_link_if

// ### slps_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module slps_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign inReady = (count_q != AW'(0) + (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
        end
        if (pop) begin
            rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // Storage carries no reset; only pointers and count need a defined value
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end
endmodule : slps_fifo

// ### slps_device.sv
// Converter end: control-port register decode, link setup state and
// quad-rate sample packing onto one eight-lane link.
// Assumes the host issues the setup writes in order; one clock domain.
module slps_device #(
    parameter int ADC_CLOCK_MHZ = 2000,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link toward the receiver end
    slps_link_if.device link,
    // Converter samples
    input wire logic sampleValid,
    input wire logic [slps_pkg::SAMPLE_W-1:0] sampleData,
    output logic sampleReady,
    // Pin and status
    input wire logic power_down_pin,
    output logic quadActive,
    output logic configError
);
    localparam int SW = slps_pkg::SAMPLE_W;
    localparam int NS = slps_pkg::SAMPLES_PER_FRAME;

    // ==========================================================
    // Configuration registers
    logic [7:0] linkCfg_q, linkCfg_d, csNp_q, csNp_d, subN_q, subN_d;
    logic [7:0] bwMode_q, bwMode_d, decim_q, decim_d, rate_q, rate_d;
    logic [7:0] linkCtrl_q, linkCtrl_d;
    logic [1:0] initStep_q, initStep_d;
    logic [2:0] pllStep_q, pllStep_d;
    logic linkUp_q, linkUp_d, pdSync1_q, pdSync2_q, pdPrev_q;
    logic [31:0] laneRate_q, laneRate_d;
    logic wr;

    assign wr = link.wrValid;
    assign link.wrReady = 1'b1;
    assign link.linkUp = linkUp_q;
    assign link.laneRateMbps = laneRate_q;

    always_comb begin
        logic reinit;
        reinit = 1'b0;
        linkCfg_d = linkCfg_q;
        csNp_d = csNp_q;
        subN_d = subN_q;
        bwMode_d = bwMode_q;
        decim_d = decim_q;
        rate_d = rate_q;
        linkCtrl_d = linkCtrl_q;
        initStep_d = initStep_q;
        pllStep_d = pllStep_q;
        linkUp_d = linkUp_q;
        if (wr) begin
            unique case (link.wrAddr)
                slps_pkg::ADDR_LINK_CFG: linkCfg_d = link.wrData;
                slps_pkg::ADDR_CS_NP: csNp_d = link.wrData;
                slps_pkg::ADDR_SUB_N: subN_d = link.wrData;
                slps_pkg::ADDR_BW_MODE: bwMode_d = link.wrData;
                slps_pkg::ADDR_DECIM: decim_d = link.wrData;
                slps_pkg::ADDR_RATE_RANGE: rate_d = link.wrData;
                slps_pkg::ADDR_LINK_CTRL: begin
                    // Power cycle 0x15 then 0x14 forces re-init
                    if (linkCtrl_q == slps_pkg::VAL_LINK_OFF &&
                        link.wrData == slps_pkg::VAL_LINK_ON) begin
                        reinit = 1'b1;
                    end
                    linkCtrl_d = link.wrData;
                end
                slps_pkg::ADDR_SOFT_RESET:
                    reinit = (link.wrData == slps_pkg::VAL_SOFT_RESET);
                slps_pkg::ADDR_PATH_RESET:
                    reinit = (link.wrData == slps_pkg::VAL_PATH_RESET);
                slps_pkg::ADDR_POWER_MODE:
                    reinit = (link.wrData[1:0] == slps_pkg::POWER_FIELD_ON);
                slps_pkg::ADDR_STARTUP: begin
                    if (link.wrData == slps_pkg::VAL_STARTUP_RST) begin
                        initStep_d = 2'h1;
                    end else if (link.wrData == slps_pkg::VAL_STARTUP_RUN &&
                                 initStep_q == 2'h1) begin
                        initStep_d = 2'h2;
                        pllStep_d = 3'h0;
                    end
                end
                slps_pkg::ADDR_PLL_CAL: begin
                    if (initStep_q == 2'h2) begin
                        if (pllStep_q == 3'h0 &&
                            link.wrData == slps_pkg::VAL_PLL_NORMAL) begin
                            pllStep_d = 3'h1;
                        end else if (pllStep_q == 3'h1 &&
                            link.wrData == slps_pkg::VAL_PLL_CAL_RST) begin
                            pllStep_d = 3'h2;
                        end else if (pllStep_q == 3'h2 &&
                            link.wrData == slps_pkg::VAL_PLL_NORMAL) begin
                            pllStep_d = 3'h3;
                        end
                    end
                end
                slps_pkg::ADDR_LOCK_CLR: begin
                    if (pllStep_q == 3'h3 &&
                        link.wrData == slps_pkg::VAL_LOCK_CLEAR) begin
                        pllStep_d = 3'h4;
                    end else if (pllStep_q == 3'h4 &&
                        link.wrData == slps_pkg::VAL_LOCK_RUN) begin
                        initStep_d = 2'h3;
                        linkUp_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Power-up via the pin also loses link state
        if (pdPrev_q && !pdSync2_q) begin
            reinit = 1'b1;
        end
        if (reinit) begin
            initStep_d = 2'h0;
            pllStep_d = 3'h0;
            linkUp_d = 1'b0;
        end
        if (pdSync2_q) begin
            linkUp_d = 1'b0;
        end
    end

    // Lane rate = M*N'*10/8*fout/L, fout = adc clock / decimation.
    // Quad packing carries five samples in 64 bits, so its lanes run at
    // four times fout, below what the general formula would give.
    always_comb begin
        logic [31:0] fout;
        fout = 32'(ADC_CLOCK_MHZ) / ((decim_q == 8'h00) ? 32'h1 :
               32'(decim_q));
        if (linkCfg_q == slps_pkg::VAL_QUAD_CFG) begin
            laneRate_d = 32'(slps_pkg::QUAD_RATE_MULT) * fout;
        end else begin
            laneRate_d = 32'((slps_pkg::LINK_M * slps_pkg::LINK_NP * 10) *
                         fout / (8 * slps_pkg::LINK_L));
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            linkCfg_q <= 8'h00;
            csNp_q <= 8'h00;
            subN_q <= 8'h00;
            bwMode_q <= 8'h00;
            decim_q <= slps_pkg::DECIM_RESET;
            rate_q <= slps_pkg::RATE_MID;
            linkCtrl_q <= 8'h00;
            initStep_q <= 2'h0;
            pllStep_q <= 3'h0;
            linkUp_q <= 1'b0;
            laneRate_q <= 32'h0;
            pdSync1_q <= 1'b0;
            pdSync2_q <= 1'b0;
            pdPrev_q <= 1'b0;
        end else begin
            linkCfg_q <= linkCfg_d;
            csNp_q <= csNp_d;
            subN_q <= subN_d;
            bwMode_q <= bwMode_d;
            decim_q <= decim_d;
            rate_q <= rate_d;
            linkCtrl_q <= linkCtrl_d;
            initStep_q <= initStep_d;
            pllStep_q <= pllStep_d;
            linkUp_q <= linkUp_d;
            laneRate_q <= laneRate_d;
            pdSync1_q <= power_down_pin;
            pdSync2_q <= pdSync1_q;
            pdPrev_q <= pdSync2_q;
        end
    end

    // ==========================================================
    // Mode qualification
    logic quad, quadActive_q, cfgErr_q;
    // Only the S4/N'16/CF0 set is accepted; the CF2 set has no encoding
    assign quad = linkCfg_q == slps_pkg::VAL_QUAD_CFG &&
                  csNp_q == slps_pkg::VAL_CS_NP16 &&
                  subN_q == slps_pkg::VAL_SUB1_N16 &&
                  bwMode_q == slps_pkg::VAL_FULL_BW &&
                  linkUp_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            quadActive_q <= 1'b0;
            cfgErr_q <= 1'b0;
        end else begin
            quadActive_q <= quad;
            cfgErr_q <= (linkCfg_q == slps_pkg::VAL_QUAD_CFG) &&
                        (bwMode_q != slps_pkg::VAL_FULL_BW);
        end
    end
    assign quadActive = quadActive_q;
    assign configError = cfgErr_q;

    // ==========================================================
    // Packing: five samples, oldest at the top, spare bits zero
    logic [SW*NS-1:0] acc_q, acc_d;
    logic [2:0] cnt_q, cnt_d;
    logic pkValid_q, pkValid_d, fifoReady;

    assign sampleReady = quad && !pkValid_q;
    always_comb begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        pkValid_d = pkValid_q;
        if (pkValid_q && fifoReady) begin
            pkValid_d = 1'b0;
        end
        if (sampleValid && sampleReady) begin
            acc_d = {acc_q[SW*(NS-1)-1:0], sampleData};
            if (cnt_q == 3'(NS - 1)) begin
                cnt_d = 3'h0;
                pkValid_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
        if (!quad) begin
            cnt_d = 3'h0;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_q <= '0;
            cnt_q <= 3'h0;
            pkValid_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            pkValid_q <= pkValid_d;
        end
    end

    slps_fifo #(.WIDTH(slps_pkg::FRAME_W), .DEPTH(FIFO_DEPTH)) uFifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .inValid(pkValid_q),
        .inReady(fifoReady),
        .inData({acc_q, {slps_pkg::SPARE_W{1'b0}}}),
        .outValid(link.frameValid),
        .outReady(link.frameReady),
        .outData(link.frameData)
    );
endmodule : slps_device

// ### slps_host.sv
// Receiver end: issues the ordered setup writes and the link
// initialization, then unpacks frames back to samples.
// Assumes the device accepts one write per cycle when wrReady is high.
module slps_host #(
    parameter logic [7:0] DECIMATION = 8'h01
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link toward the converter end
    slps_link_if.host link,
    // User side
    input wire logic startSetup,
    output logic setupDone,
    output logic rateError,
    output logic samplesValid,
    output logic [slps_pkg::SAMPLE_W*slps_pkg::SAMPLES_PER_FRAME-1:0] samples
);
    typedef enum {SLPS_IDLE, SLPS_WRITE, SLPS_DONE} slps_hstate_t;
    slps_hstate_t st_q, st_d;
    logic [3:0] idx_q, idx_d;
    logic done_q, done_d, vld_q;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] rangeSel;
    logic [slps_pkg::SAMPLE_W*slps_pkg::SAMPLES_PER_FRAME-1:0] smp_q;

    // ==========================================================
    // Range follows the rate the device reports; the decimation and
    // link writes land at least two cycles before the range write
    always_comb begin
        if (link.laneRateMbps < 32'(slps_pkg::RATE_LOWEST_TOP_MBPS)) begin
            rangeSel = slps_pkg::RATE_LOWEST;
        end else if (link.laneRateMbps <
                     32'(slps_pkg::RATE_LOW_TOP_MBPS)) begin
            rangeSel = slps_pkg::RATE_LOW;
        end else if (link.laneRateMbps <
                     32'(slps_pkg::RATE_MID_TOP_MBPS)) begin
            rangeSel = slps_pkg::RATE_MID;
        end else begin
            rangeSel = slps_pkg::RATE_HIGH;
        end
    end

    // Ordered write list: link off, config, link on, init writes.
    // Indexed by the next index so strobe and entry leave together.
    always_comb begin
        unique case (idx_d)
            4'h0: {addr, data} = {slps_pkg::ADDR_LINK_CTRL,
                                  slps_pkg::VAL_LINK_OFF};
            4'h1: {addr, data} = {slps_pkg::ADDR_BW_MODE,
                                  slps_pkg::VAL_FULL_BW};
            4'h2: {addr, data} = {slps_pkg::ADDR_DECIM, DECIMATION};
            4'h3: {addr, data} = {slps_pkg::ADDR_LINK_CFG,
                                  slps_pkg::VAL_QUAD_CFG};
            4'h4: {addr, data} = {slps_pkg::ADDR_CS_NP,
                                  slps_pkg::VAL_CS_NP16};
            4'h5: {addr, data} = {slps_pkg::ADDR_SUB_N,
                                  slps_pkg::VAL_SUB1_N16};
            4'h6: {addr, data} = {slps_pkg::ADDR_RATE_RANGE,
                                  rangeSel};
            4'h7: {addr, data} = {slps_pkg::ADDR_LINK_CTRL,
                                  slps_pkg::VAL_LINK_ON};
            4'h8: {addr, data} = {slps_pkg::ADDR_STARTUP,
                                  slps_pkg::VAL_STARTUP_RST};
            4'h9: {addr, data} = {slps_pkg::ADDR_STARTUP,
                                  slps_pkg::VAL_STARTUP_RUN};
            4'hA: {addr, data} = {slps_pkg::ADDR_PLL_CAL,
                                  slps_pkg::VAL_PLL_NORMAL};
            4'hB: {addr, data} = {slps_pkg::ADDR_PLL_CAL,
                                  slps_pkg::VAL_PLL_CAL_RST};
            4'hC: {addr, data} = {slps_pkg::ADDR_PLL_CAL,
                                  slps_pkg::VAL_PLL_NORMAL};
            4'hD: {addr, data} = {slps_pkg::ADDR_LOCK_CLR,
                                  slps_pkg::VAL_LOCK_CLEAR};
            default: {addr, data} = {slps_pkg::ADDR_LOCK_CLR,
                                  slps_pkg::VAL_LOCK_RUN};
        endcase
    end

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        done_d = done_q;
        unique case (st_q)
            SLPS_IDLE: if (startSetup) begin
                st_d = SLPS_WRITE;
                idx_d = 4'h0;
                done_d = 1'b0;
            end
            SLPS_WRITE: if (link.wrReady) begin
                if (idx_q == 4'(slps_pkg::SEQ_LEN - 1)) begin
                    st_d = SLPS_DONE;
                    done_d = 1'b1;
                end else begin
                    idx_d = idx_q + 4'h1;
                end
            end
            SLPS_DONE: begin
                // Device lost its link after a reset: redo everything
                if (!link.linkUp || startSetup) begin
                    st_d = SLPS_WRITE;
                    idx_d = 4'h0;
                    done_d = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= SLPS_IDLE;
            idx_q <= 4'h0;
            done_q <= 1'b0;
            link.wrValid <= 1'b0;
            link.wrAddr <= 16'h0000;
            link.wrData <= 8'h00;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            done_q <= done_d;
            link.wrValid <= (st_d == SLPS_WRITE);
            link.wrAddr <= addr;
            link.wrData <= data;
        end
    end

    // ==========================================================
    // Frame unpacking; frameReady follows setupDone one cycle later so the FIFO drains
    logic rateErr_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.frameReady <= 1'b0;
            vld_q <= 1'b0;
            smp_q <= '0;
            rateErr_q <= 1'b0;
        end else begin
            link.frameReady <= done_q;
            vld_q <= link.frameValid && link.frameReady;
            if (link.frameValid && link.frameReady) begin
                smp_q <= link.frameData[slps_pkg::FRAME_W-1:
                                        slps_pkg::SPARE_W];
            end
            rateErr_q <= done_q &&
                (link.laneRateMbps > 32'(slps_pkg::RATE_MAX_MBPS) ||
                 link.laneRateMbps < 32'(slps_pkg::RATE_MIN_MBPS));
        end
    end
    assign setupDone = done_q;
    assign rateError = rateErr_q;
    assign samplesValid = vld_q;
    assign samples = smp_q;
endmodule : slps_host

// ### slps_sva.sv
// Checker on the link that joins the host end to the converter end.
// Assumes one clock and a synchronous active-high reset.
module slps_checker
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link signals
    input wire logic wrValid,
    input wire logic wrReady,
    input wire logic [15:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic linkUp,
    input wire logic [31:0] laneRateMbps,
    input wire logic frameValid,
    input wire logic frameReady,
    input wire logic [63:0] frameData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Link checks
    AST_SPARE: assert property (
        frameValid |-> frameData[3:0] == 4'h0) else $error("spare set");
    AST_HOLD: assert property (
        frameValid && !frameReady |=> frameValid && $stable(frameData))
        else $error("frame dropped");
    AST_RATE_MAX: assert property (
        linkUp |-> laneRateMbps <= 32'h3E80) else $error("rate high");
    AST_RATE_MIN: assert property (
        linkUp |-> laneRateMbps >= 32'hD48) else $error("rate low");
    AST_ORDER: assert property (
        wrValid && wrAddr == 16'h1228 && wrData == 8'h4F
        |-> $past(wrValid) && $past(wrAddr) == 16'h0571
        && $past(wrData) == 8'h14) else $error("init before link on");
    AST_RANGE: assert property (
        wrValid && wrAddr == 16'h056E && laneRateMbps >= 32'h1A5E
        && laneRateMbps < 32'h34BC |-> wrData == 8'h00)
        else $error("wrong rate range");
    AST_OFF: assert property (
        wrValid && wrAddr == 16'h0571 && wrData == 8'h15
        |-> ##[1:2] !linkUp) else $error("link kept up");
    AST_UP: assert property (
        wrValid && wrAddr == 16'h1262 && wrData == 8'h00
        && $past(wrData) == 8'h08 |-> ##[1:3] linkUp)
        else $error("link not up");
    AST_QUIET: assert property (
        $fell(sys_rst) |-> !linkUp && !frameValid) else $error("busy");
endmodule : slps_checker

// ### tb_top.sv
// Bench for both ends; pair one runs host to device, pair two has the
// bench as host so it can stall frames and misorder writes.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0;
    logic sys_rst = 1;
    logic startSetup = 0;
    logic setupDone, rateError, samplesValid, ok;
    logic [59:0] samples;
    logic pd[2] = '{default: 1'h0};
    logic sv[2] = '{default: 1'h0};
    logic sr[2], qa[2], ce[2];
    logic [11:0] sd[2] = '{default: 12'h0};
    logic [23:0] initList[15] = '{24'h057115, 24'h020000, 24'h020101,
        24'h0570FE, 24'h058B0F, 24'h058F2F, 24'h056E00, 24'h057114,
        24'h12284F, 24'h12280F, 24'h122200, 24'h122204, 24'h122200,
        24'h126208, 24'h126200};
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    slps_link_if lk[2] ();
    always #20 clock = ~clock;
    for (genvar i = 0; i < 2; i++) begin : g
        slps_device slps_device_i (.clock(clock), .sys_rst(sys_rst),
            .link(lk[i].device), .sampleValid(sv[i]), .sampleData(sd[i]),
            .sampleReady(sr[i]), .power_down_pin(pd[i]),
            .quadActive(qa[i]), .configError(ce[i]));
    end
    slps_host slps_host_i (.clock(clock), .sys_rst(sys_rst),
        .link(lk[0].host), .startSetup(startSetup), .setupDone(setupDone),
        .rateError(rateError), .samplesValid(samplesValid),
        .samples(samples));
    slps_checker slps_checker_i (.clock(clock), .sys_rst(sys_rst),
        .wrValid(lk[0].wrValid), .wrReady(lk[0].wrReady),
        .wrAddr(lk[0].wrAddr), .wrData(lk[0].wrData),
        .linkUp(lk[0].linkUp), .laneRateMbps(lk[0].laneRateMbps),
        .frameValid(lk[0].frameValid), .frameReady(lk[0].frameReady),
        .frameData(lk[0].frameData));
    // ==========================================================
    // Shared tasks; wr and idle drive at the falling edge
    task automatic chk(string s, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [23:0] w);
        lk[1].wrValid = 1'h1;
        {lk[1].wrAddr, lk[1].wrData} = w;
        while (lk[1].wrReady !== 1'h1) @(negedge clock);
        @(negedge clock);
    endtask : wr
    task automatic idle(int k);
        lk[1].wrValid = 1'h0;
        sv[0] = 1'h0;
        sv[1] = 1'h0;
        repeat (k) @(negedge clock);
    endtask : idle
    task automatic init2;
        foreach (initList[k]) wr(initList[k]);
        idle(4);
    endtask : init2
    task automatic wrap_up;
        $display("compares %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Scenarios
    task automatic t_setup;
        startSetup = 1'h1;
        @(negedge clock);
        startSetup = 1'h0;
        repeat (60) if (setupDone !== 1'h1) @(negedge clock);
        // quadActive and rateError trail setupDone by a register stage
        repeat (2) @(negedge clock);
        chk("done", setupDone, 1);
        chk("link", lk[0].linkUp, 1);
        chk("rate", lk[0].laneRateMbps, 4*2000);
        chk("rateErr", rateError, 0);
        chk("quad", qa[0], 1);
    endtask : t_setup
    task automatic t_pack;
        for (int k = 0; k < 5; k++) begin
            sv[0] = 1'h1;
            sd[0] = 12'hA00 + 12'(k);
            while (sr[0] !== 1'h1) @(negedge clock);
            @(negedge clock);
        end
        idle(0);
        repeat (40) if (samplesValid !== 1'h1) @(negedge clock);
        chk("samples", samples, 60'hA00A01A02A03A04);
        pd[0] = 1'h1;
        idle(8);
        chk("pdDrop", lk[0].linkUp, 0);
        pd[0] = 1'h0;
        repeat (200) if (lk[0].linkUp !== 1'h1) @(negedge clock);
        chk("relink", lk[0].linkUp, 1);
    endtask : t_pack
    task automatic t_resets;
        logic [23:0] rk[2] = '{24'h000081, 24'h000102};
        wr(24'h126208);
        idle(4);
        chk("order", lk[1].linkUp, 0);
        foreach (rk[k]) begin
            init2();
            chk("up2", lk[1].linkUp, 1);
            wr(24'h020001);
            idle(3);
            chk("bw", ce[1], 1);
            wr(24'h057000);
            idle(3);
            chk("rate16", lk[1].laneRateMbps, 2*16*10*2000/(8*8));
            wr(rk[k]);
            idle(4);
            chk("drop", lk[1].linkUp, 0);
        end
    endtask : t_resets
    task automatic t_fill;
        init2();
        n = 0;
        repeat (40) begin
            sv[1] = 1'h1;
            sd[1] = 12'(n);
            ok = sr[1];
            @(negedge clock);
            n += int'(ok);
        end
        idle(2);
        chk("filled", n, 25);
        lk[1].frameReady = 1'h1;
        chk("head", lk[1].frameData, 64'h0000010020030040);
        n = 0;
        repeat (20) begin
            ok = lk[1].frameValid;
            @(negedge clock);
            n += int'(ok);
        end
        chk("drained", n, 5);
    endtask : t_fill
    initial begin
        lk[1].wrValid = 1'h0;
        lk[1].wrAddr = 16'h0;
        lk[1].wrData = 8'h0;
        lk[1].frameReady = 1'h0;
        repeat (20) @(negedge clock);
        sys_rst = 1'h0;
        t_setup();
        t_pack();
        t_resets();
        t_fill();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        wrap_up();
    end
endmodule : tb_top
